// ===== dv/ftaap_chk.sv
`default_nettype none
module ftaap_chk #(
  parameter int unsigned FRAME_CYCLES = 9720
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // receive side
  input wire logic rx_out_of_frame,
  input wire logic [ftaap_pkg::ALARM_COUNT-1:0] rx_alarm_active,
  input wire logic rx_timing_clock,
  input wire logic rx_frame_marker,
  input wire logic rx_alarm_summary,
  // transmit side
  input wire logic tx_frame_align_in,
  input wire logic tx_timing_clock,
  input wire logic tx_frame_marker,
  // protection bus
  input wire logic rx_febe_clock,
  input wire logic rx_febe_data,
  input wire logic [2:0] rx_rdi_code,
  input wire logic tx_febe_clock,
  input wire logic tx_febe_data,
  input wire logic [2:0] tx_rdi_code,
  input wire logic [ftaap_pkg::PROT_W-1:0] protect_in,
  input wire logic [ftaap_pkg::PROT_W-1:0] protect_out,
  input wire logic [ftaap_pkg::PROT_W-1:0] protect_oe,
  input wire logic protect_port_out_en
);
  import ftaap_pkg::*;
  localparam int PER = 2 * FRAME_CYCLES;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // --------------------------------
  // cycles since the last marker; skip after out of frame or realignment
  // --------------------------------
  logic [15:0] rx_gap;
  logic [15:0] tx_gap;
  logic rx_skip;
  logic tx_skip;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_gap <= 16'h0;
      rx_skip <= 1'b1;
    end else if ($rose(rx_frame_marker)) begin
      rx_gap <= 16'h1;
      rx_skip <= rx_out_of_frame;
    end else begin
      rx_gap <= rx_gap + 16'h1;
      rx_skip <= rx_skip | rx_out_of_frame;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_gap <= 16'h0;
      tx_skip <= 1'b1;
    end else if ($rose(tx_frame_marker)) begin
      tx_gap <= 16'h1;
      tx_skip <= !tx_timing_clock && tx_frame_align_in;
    end else begin
      tx_gap <= tx_gap + 16'h1;
      tx_skip <= tx_skip | (!tx_timing_clock && tx_frame_align_in);
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  property p_clk_run; $past(reset_n) |-> tx_timing_clock == rx_timing_clock && rx_timing_clock != $past(rx_timing_clock); endproperty
  a_clk_run: assert property (p_clk_run) else $error("timing clocks stall or differ");
  property p_rx_edge; $past(reset_n) && $changed(rx_frame_marker) |-> rx_timing_clock; endproperty
  a_rx_edge: assert property (p_rx_edge) else $error("rx marker moved off a rise");
  property p_rx_width; $rose(rx_frame_marker) |-> ##1 rx_frame_marker ##1 !rx_frame_marker; endproperty
  a_rx_width: assert property (p_rx_width) else $error("rx marker width wrong");
  property p_rx_period; $rose(rx_frame_marker) && !rx_skip |-> rx_gap == PER; endproperty
  a_rx_period: assert property (p_rx_period) else $error("rx marker period wrong");
  property p_tx_width; $rose(tx_frame_marker) |-> tx_timing_clock ##1 tx_frame_marker ##1 (!tx_frame_marker || tx_skip); endproperty
  a_tx_width: assert property (p_tx_width) else $error("tx marker width or edge wrong");
  property p_tx_period; $rose(tx_frame_marker) && !tx_skip |-> tx_gap == PER; endproperty
  a_tx_period: assert property (p_tx_period) else $error("tx marker period wrong");
  property p_tx_align; !tx_timing_clock && tx_frame_align_in |=> tx_frame_marker && tx_timing_clock; endproperty
  a_tx_align: assert property (p_tx_align) else $error("alignment pulse not followed");
  property p_alarm_low; (rx_alarm_active == 15'h0) [*2] |=> !rx_alarm_summary; endproperty
  a_alarm_low: assert property (p_alarm_low) else $error("alarm summary high without alarm");
  property p_alarm_rise; $rose(rx_alarm_summary) |-> rx_timing_clock && $past(rx_alarm_active) != 15'h0; endproperty
  a_alarm_rise: assert property (p_alarm_rise) else $error("alarm summary rose without cause");
  property p_prot_oe; protect_oe == {5{protect_port_out_en}}; endproperty
  a_prot_oe: assert property (p_prot_oe) else $error("bus enables disagree");
  property p_prot_out; $past(reset_n) && protect_port_out_en |-> protect_out == $past({rx_rdi_code, rx_febe_data, rx_febe_clock}); endproperty
  a_prot_out: assert property (p_prot_out) else $error("bus output not rx overhead");
  property p_prot_in; $past(reset_n) && !protect_port_out_en && !$past(protect_port_out_en) |-> {tx_rdi_code, tx_febe_data, tx_febe_clock} == $past(protect_in); endproperty
  a_prot_in: assert property (p_prot_in) else $error("bus input not passed to tx");
endmodule
bind ftaap_top ftaap_chk #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (
  .clk(clk), .reset_n(reset_n), .rx_out_of_frame(rx_out_of_frame), .rx_alarm_active(rx_alarm_active),
  .rx_timing_clock(rx_timing_clock), .rx_frame_marker(rx_frame_marker), .rx_alarm_summary(rx_alarm_summary),
  .tx_frame_align_in(tx_frame_align_in), .tx_timing_clock(tx_timing_clock), .tx_frame_marker(tx_frame_marker),
  .rx_febe_clock(rx_febe_clock), .rx_febe_data(rx_febe_data), .rx_rdi_code(rx_rdi_code),
  .tx_febe_clock(tx_febe_clock), .tx_febe_data(tx_febe_data), .tx_rdi_code(tx_rdi_code), .protect_in(protect_in),
  .protect_out(protect_out), .protect_oe(protect_oe), .protect_port_out_en(protect_port_out_en)
);
`default_nettype wire

// ===== dv/ftaap_mate.sv
`default_nettype none
module ftaap_mate (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // bench commands
  input wire logic go,
  input wire logic drive,
  input wire logic [4:0] val,
  // device side
  input wire logic tx_timing_clock,
  output logic tx_frame_align_in,
  output logic [4:0] bus_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend;
  logic [4:0] last;
  // one pulse of a whole timing period per request, low otherwise
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pend <= 1'b0;
      tx_frame_align_in <= 1'b0;
    end else if (tx_timing_clock) begin
      tx_frame_align_in <= pend | go;
      pend <= 1'b0;
    end else begin
      pend <= pend | go;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      last <= 5'h0;
    end else begin
      last <= bus_q;
    end
  end
  // released lines flip every cycle so no stale value can pass
  assign bus_q = drive ? val : ~last;
endmodule
`default_nettype wire

// ===== dv/test_frame_timing_alarm_aps_port.sv
`default_nettype none
module test_frame_timing_alarm_aps_port;
  timeunit 1ns;
  timeprecision 1ns;
  import ftaap_pkg::*;
  localparam int FC = 8;
  localparam int PER = 2 * FC;
  logic clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  // answers are always welcome, so bready and rready stay high and are never toggled between transfers
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic rx_out_of_frame = 1'b0, rx_febe_clock = 1'b0, rx_febe_data = 1'b0, go = 1'b0, drive = 1'b0;
  logic [14:0] rx_alarm_active = 15'h0;
  logic [2:0] rx_rdi_code = 3'h0;
  logic [4:0] val = 5'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, rx_timing_clock;
  wire logic rx_frame_marker, rx_alarm_summary, tx_frame_align_in, tx_timing_clock, tx_frame_marker;
  wire logic tx_febe_clock, tx_febe_data, protect_port_out_en;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [2:0] tx_rdi_code;
  wire logic [4:0] protect_in, protect_out, protect_oe, mate_q;
  int miscompares = 0, samples_checked = 0, cycles = 0, g;
  logic [14:0] en, act;
  ftaap_top #(.FRAME_CYCLES(FC)) dut (.*);
  ftaap_mate u_mate (.clk(clk), .reset_n(reset_n), .go(go), .drive(drive), .val(val),
    .tx_timing_clock(tx_timing_clock), .tx_frame_align_in(tx_frame_align_in), .bus_q(mate_q));
  assign protect_in = (protect_oe & protect_out) | (~protect_oe & mate_q);
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      end_of_test();
    end
  end
  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic alarm_of(logic [14:0] a, logic [14:0] e);
    return |(a & e);
  endfunction
  function automatic logic [4:0] bus_of(logic [2:0] rdi, logic d, logic c);
    return {rdi, d, c};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axi(input bit we, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, tw, tr, done;
    logic [31:0] q;
    logic [1:0] rs;
    int n;
    n = 0;
    done = 1'b0;
    if (we) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
    end
    while (!done && n < 40) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      done = we ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      rs = we ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      n++;
    end
    chk(done, 1'b1);
    chk(rs, r);
    if (!we) chk(q, d);
  endtask
  // cycles from a rise of the start signal to the next rise of a marker
  task automatic gap(input int sel, output int n_out);
    logic m, f, pm, pf;
    int k;
    k = 0;
    n_out = 0;
    pm = 1'b1;
    pf = sel != 2;
    for (int n = 0; n < 200 && k < 2; n++) begin
      @(negedge clk);
      m = sel == 0 ? rx_frame_marker : tx_frame_marker;
      f = sel == 2 ? tx_frame_align_in : m;
      if (k == 1) n_out++;
      if (k == 1 && m && !pm) k = 2;
      if (k == 0 && f && !pf) k = 1;
      pm = m;
      pf = f;
    end
    @(posedge clk);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    void'($urandom(87));
    cyc(12);
    reset_n <= 1'b1;
    @(posedge clk);
    axi(0, REG_CONTROL, 32'h2, RESP_OKAY);
    axi(0, REG_ALARM_ENABLE, 32'h7fff, RESP_OKAY);
    axi(0, REG_INT_MASK, 32'h0, RESP_OKAY);
    axi(0, 8'h40, 32'h0, RESP_SLVERR);
    axi(1, 8'h40, 32'h1, RESP_SLVERR);
    axi(1, REG_ALARM_STATE, 32'hffffffff, RESP_OKAY);
    gap(0, g);
    chk(32'(g), PER);
    gap(1, g);
    chk(32'(g), PER);
    rx_out_of_frame <= 1'b1;
    cyc(4);
    gap(0, g);
    chk(32'(g), 0);
    rx_out_of_frame <= 1'b0;
    // the first pulse shifts the frame, later ones repeat it a whole number of frames on
    for (int i = 0; i < 4; i++) begin
      gap(1, g);
      chk(32'(g), PER);
      cyc(i == 0 ? $urandom_range(PER - 4, 1) : PER * $urandom_range(3, 1) - 3);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      gap(2, g);
      chk(32'(g), 1);
    end
    for (int i = 0; i < 19; i++) begin
      en = 15'($urandom());
      act = i < ALARM_COUNT ? 15'h1 << i : 15'($urandom());
      if (i == 18) act = 15'h0;
      axi(1, REG_ALARM_ENABLE, {17'h0, en}, RESP_OKAY);
      rx_alarm_active <= act;
      cyc(4);
      chk(rx_alarm_summary, alarm_of(act, en));
      axi(0, REG_ALARM_STATE, {15'h0, alarm_of(act, en), 1'b0, act}, RESP_OKAY);
    end
    axi(1, REG_ALARM_ENABLE, 32'h7fff, RESP_OKAY);
    axi(1, REG_INT_MASK, 32'h8, RESP_OKAY);
    axi(1, REG_INT_STATUS, 32'hf, RESP_OKAY);
    cyc(2);
    chk(irq, 1'b0);
    rx_alarm_active <= 15'h1;
    cyc(6);
    chk(irq, 1'b1);
    axi(1, REG_INT_MASK, 32'h0, RESP_OKAY);
    cyc(2);
    chk(irq, 1'b0);
    axi(1, REG_INT_MASK, 32'h8, RESP_OKAY);
    cyc(2);
    chk(irq, 1'b1);
    axi(1, REG_INT_STATUS, 32'h8, RESP_OKAY);
    cyc(2);
    chk(irq, 1'b0);
    axi(0, REG_INT_STATUS, 32'h3, RESP_OKAY);
    drive <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      val <= 5'($urandom());
      cyc(3);
      chk(bus_of(tx_rdi_code, tx_febe_data, tx_febe_clock), val);
      axi(0, REG_PROT_STATE, {27'h0, val}, RESP_OKAY);
    end
    drive <= 1'b0;
    axi(1, REG_CONTROL, 32'h3, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      {rx_rdi_code, rx_febe_data, rx_febe_clock} <= 5'($urandom());
      cyc(3);
      chk(protect_out, bus_of(rx_rdi_code, rx_febe_data, rx_febe_clock));
      chk(protect_oe, 5'h1f);
      axi(0, REG_PROT_STATE, {27'h0, bus_of(rx_rdi_code, rx_febe_data, rx_febe_clock)}, RESP_OKAY);
    end
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(protect_oe, 5'h0);
    axi(0, REG_CONTROL, 32'h2, RESP_OKAY);
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== verilog/ftaap_frame_timer.sv
`default_nettype none
module ftaap_frame_timer #(
  parameter int unsigned PERIOD = 9720
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // control
  input wire logic run,
  input wire logic restart,
  // timing
  output logic timing_clock,
  output logic marker,
  output logic rise
);
  localparam int unsigned CW = $clog2(PERIOD);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] count;

  initial begin
    if (PERIOD < 2) begin
      $error("frame period too short");
    end
  end

  // rise marks the clk edge at which timing_clock goes high
  assign rise = clk_en & ~timing_clock;

  // divide by two gives an exact 50% duty timing clock
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      timing_clock <= 1'b0;
    end else if (clk_en) begin
      timing_clock <= ~timing_clock;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
    end else if (rise) begin
      if (restart || count == LAST) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

  // marker is only touched at a rising edge, so it spans one timing cycle, or more while restart is high at each following rise
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      marker <= 1'b0;
    end else if (rise) begin
      marker <= run && (restart || count == LAST);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/ftaap_pkg.sv
`default_nettype none
package ftaap_pkg;
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned FRAME_CYCLES = 9720;
  localparam int unsigned ALARM_COUNT = 15;
  localparam int unsigned EVENT_COUNT = 4;
  localparam int unsigned PROT_W = 5;

  // alarm condition bit positions
  typedef enum logic [3:0] {
    ALM_LINE_AIS, ALM_PATH_AIS, ALM_LINE_RDI, ALM_PATH_RDI, ALM_PATH_ERDI,
    ALM_LOS, ALM_LOF, ALM_OOF, ALM_LOP, ALM_LOP_CONCAT, ALM_LCD,
    ALM_SF_BER, ALM_SD_BER, ALM_TRACE_MISMATCH, ALM_LABEL_MISMATCH
  } ftaap_alarm_type;

  // protection bus bit positions
  localparam int unsigned PROT_FEBE_CLK = 0;
  localparam int unsigned PROT_FEBE_DATA = 1;
  localparam int unsigned PROT_RDI_LSB = 2;
  localparam int unsigned PROT_RDI_MSB = 4;

  // register byte offsets
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_ALARM_ENABLE = 8'h04;
  localparam logic [7:0] REG_ALARM_STATE = 8'h08;
  localparam logic [7:0] REG_INT_STATUS = 8'h0c;
  localparam logic [7:0] REG_INT_MASK = 8'h10;
  localparam logic [7:0] REG_PROT_STATE = 8'h14;

  // control fields
  localparam int unsigned CTL_DRIVE_EN = 0;
  localparam int unsigned CTL_ALIGN_EN = 1;
  localparam int unsigned CTL_W = 2;
  localparam logic [CTL_W-1:0] CONTROL_RESET = 2'h2;
  localparam logic [ALARM_COUNT-1:0] ALARM_ENABLE_RESET = 15'h7fff;
  localparam logic [EVENT_COUNT-1:0] INT_MASK_RESET = 4'h0;

  // alarm state fields
  localparam int unsigned ST_SUMMARY = 16;
  localparam int unsigned ST_OOF = 17;

  // interrupt event positions
  localparam int unsigned EV_RX_MARK = 0;
  localparam int unsigned EV_TX_MARK = 1;
  localparam int unsigned EV_ALIGN = 2;
  localparam int unsigned EV_ALARM_RISE = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== verilog/ftaap_sticky_bank.sv
`default_nettype none
module ftaap_sticky_bank #(
  parameter int unsigned WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // events and software access
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic [WIDTH-1:0] clear_bits,
  input wire logic [WIDTH-1:0] mask,
  // state
  output logic [WIDTH-1:0] status,
  output logic irq
);
  logic [WIDTH-1:0] next_status;

  initial begin
    if (WIDTH < 1) begin
      $error("sticky bank needs at least one bit");
    end
  end

  // a set arriving with its clear wins
  assign next_status = (status & ~clear_bits) | set_pulse;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= '0;
    end else if (clk_en) begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(next_status & mask);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/ftaap_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
module ftaap_top #(
  parameter int unsigned FRAME_CYCLES = ftaap_pkg::FRAME_CYCLES,
  parameter int unsigned ADDR_W = 8
) (
  // clock, enable and reset
  input wire logic clk,
  input wire logic clk_en,
  input wire logic reset_n,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq,
  // receive timing and alarms
  input wire logic rx_out_of_frame,
  input wire logic [ftaap_pkg::ALARM_COUNT-1:0] rx_alarm_active,
  output logic rx_timing_clock,
  output logic rx_frame_marker,
  output logic rx_alarm_summary,
  // transmit timing
  input wire logic tx_frame_align_in,
  output logic tx_timing_clock,
  output logic tx_frame_marker,
  // receive path overhead data towards the protection bus
  input wire logic rx_febe_clock,
  input wire logic rx_febe_data,
  input wire logic [2:0] rx_rdi_code,
  // data for the transmit path overhead generator
  output logic tx_febe_clock,
  output logic tx_febe_data,
  output logic [2:0] tx_rdi_code,
  // protection bus pins
  input wire logic [ftaap_pkg::PROT_W-1:0] protect_in,
  output logic [ftaap_pkg::PROT_W-1:0] protect_out,
  output logic [ftaap_pkg::PROT_W-1:0] protect_oe,
  output logic protect_port_out_en
);
  import ftaap_pkg::*;

  initial begin
    if (FRAME_CYCLES < 2) begin
      $error("FRAME_CYCLES must be at least 2");
    end
    if (ADDR_W < 5 || ADDR_W > 8) begin
      $error("ADDR_W must lie between 5 and 8");
    end
  end

  // ----------------------------------------------------------------
  // registers and timing instances
  // ----------------------------------------------------------------
  logic [CTL_W-1:0] control;
  logic [ALARM_COUNT-1:0] alarm_enable;
  logic [EVENT_COUNT-1:0] int_mask;
  logic [EVENT_COUNT-1:0] int_status;
  logic [EVENT_COUNT-1:0] int_clear;
  logic [EVENT_COUNT-1:0] events;
  logic rx_rise;
  logic tx_rise;
  logic rx_mark_q;
  logic tx_mark_q;
  logic align_pulse;
  logic next_summary;
  logic [PROT_W-1:0] prot_level;

  // the alignment input counts only at a transmit rising edge
  assign align_pulse = tx_rise & tx_frame_align_in & control[CTL_ALIGN_EN];

  ftaap_frame_timer #(
    .PERIOD(FRAME_CYCLES)
  ) u_rx_timer (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .run(~rx_out_of_frame),
    .restart(1'b0),
    .timing_clock(rx_timing_clock),
    .marker(rx_mark_q),
    .rise(rx_rise)
  );

  ftaap_frame_timer #(
    .PERIOD(FRAME_CYCLES)
  ) u_tx_timer (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .run(1'b1),
    .restart(align_pulse),
    .timing_clock(tx_timing_clock),
    .marker(tx_mark_q),
    .rise(tx_rise)
  );

  assign rx_frame_marker = rx_mark_q;
  assign tx_frame_marker = tx_mark_q;

  // ----------------------------------------------------------------
  // receive alarm summary
  // ----------------------------------------------------------------
  assign next_summary = |(rx_alarm_active & alarm_enable);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_alarm_summary <= 1'b0;
    end else if (rx_rise) begin
      rx_alarm_summary <= next_summary;
    end
  end

  // ----------------------------------------------------------------
  // protection bus
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      protect_port_out_en <= 1'b0;
      protect_oe <= '0;
    end else if (clk_en) begin
      protect_port_out_en <= control[CTL_DRIVE_EN];
      protect_oe <= {PROT_W{control[CTL_DRIVE_EN]}};
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      protect_out <= '0;
    end else if (clk_en) begin
      protect_out[PROT_FEBE_CLK] <= rx_febe_clock;
      protect_out[PROT_FEBE_DATA] <= rx_febe_data;
      protect_out[PROT_RDI_MSB:PROT_RDI_LSB] <= rx_rdi_code;
    end
  end

  // transmit overhead data follows the bus only while it is an input
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_febe_clock <= 1'b0;
      tx_febe_data <= 1'b0;
      tx_rdi_code <= 3'h0;
    end else if (clk_en && !protect_port_out_en) begin
      tx_febe_clock <= protect_in[PROT_FEBE_CLK];
      tx_febe_data <= protect_in[PROT_FEBE_DATA];
      tx_rdi_code <= protect_in[PROT_RDI_MSB:PROT_RDI_LSB];
    end
  end

  assign prot_level = protect_port_out_en ? protect_out : protect_in;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[EV_RX_MARK] = rx_rise & ~rx_out_of_frame & rx_mark_q;
    events[EV_TX_MARK] = tx_rise & tx_mark_q;
    events[EV_ALIGN] = align_pulse;
    events[EV_ALARM_RISE] = rx_rise & next_summary & ~rx_alarm_summary;
  end

  ftaap_sticky_bank #(
    .WIDTH(EVENT_COUNT)
  ) u_events (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .set_pulse(events),
    .clear_bits(int_clear),
    .mask(int_mask),
    .status(int_status),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wr_mask;
  logic [7:0] wr_off;

  assign do_write = clk_en & aw_held & w_held & ~s_axi_bvalid;
  assign wr_off = 8'(aw_addr);
  assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_off[7:2] <= REG_PROT_STATE[7:2] && wr_off[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control <= CONTROL_RESET;
      alarm_enable <= ALARM_ENABLE_RESET;
      int_mask <= INT_MASK_RESET;
    end else if (do_write) begin
      if (wr_off == REG_CONTROL) begin
        control <= CTL_W'((32'(control) & ~wr_mask) | (w_data & wr_mask));
      end
      if (wr_off == REG_ALARM_ENABLE) begin
        alarm_enable <= ALARM_COUNT'((32'(alarm_enable) & ~wr_mask) | (w_data & wr_mask));
      end
      if (wr_off == REG_INT_MASK) begin
        int_mask <= EVENT_COUNT'((32'(int_mask) & ~wr_mask) | (w_data & wr_mask));
      end
    end
  end

  // write one to clear, applied in the write cycle itself
  assign int_clear = (do_write && wr_off == REG_INT_STATUS) ? EVENT_COUNT'(w_data & wr_mask) : '0;

  // ----------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic rd_ok;
  logic [7:0] rd_off;

  assign rd_off = 8'(s_axi_araddr);
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (rd_off)
      REG_CONTROL: begin
        rd_word[CTL_W-1:0] = control;
      end
      REG_ALARM_ENABLE: begin
        rd_word[ALARM_COUNT-1:0] = alarm_enable;
      end
      REG_ALARM_STATE: begin
        rd_word[ALARM_COUNT-1:0] = rx_alarm_active;
        rd_word[ST_SUMMARY] = rx_alarm_summary;
        rd_word[ST_OOF] = rx_out_of_frame;
      end
      REG_INT_STATUS: begin
        rd_word[EVENT_COUNT-1:0] = int_status;
      end
      REG_INT_MASK: begin
        rd_word[EVENT_COUNT-1:0] = int_mask;
      end
      REG_PROT_STATE: begin
        rd_word[PROT_W-1:0] = prot_level;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire
